// ---- p3fs_port.v ----
// Eight-pin port with per-pin function select, drive control and APB registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "p3fs_regs.vh"

module p3fs_port (
  input  wire        ref_clk_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [15:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  input  wire [7:0]  pin_in_i,
  output wire [7:0]  pin_out_o,
  output wire [7:0]  pin_oe_o,
  output wire [7:0]  pull_up_o,
  output wire [7:0]  pull_down_o,
  input  wire        i2c0_sda_low_i,
  input  wire        i2c0_scl_low_i,
  input  wire        i2c1_sda_low_i,
  input  wire        i2c1_scl_low_i,
  input  wire        serial_data_out_i,
  input  wire        serial_clock_out_i,
  input  wire        serial_clock_oe_i,
  input  wire        uart_transmit_i,
  input  wire        buzzer_output_i,
  input  wire        function_timer_out_ch4_i,
  input  wire        function_timer_out_ch5_i,
  input  wire        function_timer_out_ch6_i,
  input  wire        function_timer_out_ch7_i,
  input  wire        fifo_serial_data_out_i,
  input  wire        fifo_serial_clock_out_i,
  input  wire        fifo_serial_clock_oe_i,
  input  wire        fifo_serial_chip_select_out_i,
  input  wire        fifo_serial_chip_select_oe_i,
  input  wire        fifo_uart_transmit_i,
  output wire        i2c0_sda_in_o,
  output wire        i2c0_scl_in_o,
  output wire        i2c1_sda_in_o,
  output wire        i2c1_scl_in_o,
  output wire        serial_data_in_o,
  output wire        serial_clock_in_o,
  output wire        uart_receive_o,
  output wire        fifo_serial_data_in_o,
  output wire        fifo_serial_clock_in_o,
  output wire        fifo_serial_chip_select_in_o,
  output wire        fifo_uart_receive_o,
  output wire [7:0]  external_irq_in_o
);

  reg  [7:0]  pin_data_ff;
  reg  [7:0]  pin_direction_ff;
  reg  [15:0] drive_control_ff;
  reg  [15:0] pin_function_select_ff;
  reg  [7:0]  pin_level_ff;
  reg  [7:0]  pin_out_ff;
  reg  [7:0]  pin_oe_ff;
  reg  [7:0]  pull_up_ff;
  reg  [7:0]  pull_down_ff;
  reg  [7:0]  nxt_pin_out;
  reg  [7:0]  nxt_pin_oe;
  reg  [7:0]  nxt_pull_up;
  reg  [7:0]  nxt_pull_down;
  reg  [7:0]  fn_val;
  reg  [7:0]  fn_en;
  reg  [1:0]  fn_code [0:7];
  reg  [1:0]  drv_code [0:7];
  reg  [31:0] rd_mux;
  reg         addr_hit;
  // Separate loop indices, one per combinational process
  integer     i;
  integer     j;

  wire access   = psel_i & penable_i;
  wire wr_acc   = access & pwrite_i;
  wire hit_data = (paddr_i == `P3FS_OFS_DATA);
  wire hit_dir  = (paddr_i == `P3FS_OFS_DIR);
  wire hit_ctrl = (paddr_i == `P3FS_OFS_CTRL);
  wire hit_mode = (paddr_i == `P3FS_OFS_MODE);

  // Zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;

  // Register writes; byte lanes let each half be written alone
  // Lanes 2 and 3 are ignored; no register is wider than 16 bits
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_data_ff            <= `P3FS_RST_DATA;
      pin_direction_ff       <= `P3FS_RST_DIR;
      drive_control_ff       <= `P3FS_RST_CTRL;
      pin_function_select_ff <= `P3FS_RST_MODE;
    end else if (wr_acc) begin
      if (hit_data && pstrb_i[0]) begin
        pin_data_ff <= pwdata_i[7:0];
      end
      if (hit_dir && pstrb_i[0]) begin
        pin_direction_ff <= pwdata_i[7:0];
      end
      if (hit_ctrl && pstrb_i[0]) begin
        drive_control_ff[7:0] <= pwdata_i[7:0];
      end
      if (hit_ctrl && pstrb_i[1]) begin
        drive_control_ff[15:8] <= pwdata_i[15:8];
      end
      if (hit_mode && pstrb_i[0]) begin
        pin_function_select_ff[7:0] <= pwdata_i[7:0];
      end
      if (hit_mode && pstrb_i[1]) begin
        pin_function_select_ff[15:8] <= pwdata_i[15:8];
      end
    end
  end

  // Read mux; input-direction bits show the sampled pin level
  always @* begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    case (1'b1)
      hit_data: rd_mux[7:0] = (pin_level_ff & pin_direction_ff)
                             | (pin_data_ff & ~pin_direction_ff);
      hit_dir:  rd_mux[7:0] = pin_direction_ff;
      hit_ctrl: rd_mux[15:0] = drive_control_ff;
      hit_mode: rd_mux[15:0] = pin_function_select_ff;
      default:  addr_hit = 1'b0;
    endcase
  end

  // Read data and error are flopped in the setup cycle, valid in access
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i & ~penable_i) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= ~addr_hit;
    end
  end

  // Pins are treated as synchronous; one stage only aligns reads
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_level_ff <= 8'h00;
    end else begin
      pin_level_ff <= pin_in_i;
    end
  end

  // Split codes: low bit at index, high bit at index plus eight
  always @* begin
    for (j = 0; j < 8; j = j + 1) begin
      fn_code[j]  = {pin_function_select_ff[j + `P3FS_HI_BYTE_LSB],
                     pin_function_select_ff[j]};
      drv_code[j] = {drive_control_ff[j + `P3FS_HI_BYTE_LSB],
                     drive_control_ff[j]};
    end
  end

  // Output value and enable of the selected function, per pin.
  // Prohibited codes give value 0 with enable, so the drive stage
  // floats or pulls low depending on drive type.
  // Input-only functions clear the enable so the pad never fights.
  always @* begin
    fn_val = pin_data_ff;
    fn_en  = 8'hFF;
    case (fn_code[0])
      `P3FS_FN_SECOND: fn_val[0] = ~i2c0_sda_low_i;
      `P3FS_FN_THIRD:  fn_val[0] = serial_data_out_i;
      `P3FS_FN_FOURTH: fn_en[0]  = 1'b0;
      default:         fn_val[0] = pin_data_ff[0];
    endcase
    case (fn_code[1])
      `P3FS_FN_SECOND: fn_val[1] = ~i2c0_scl_low_i;
      `P3FS_FN_THIRD:  fn_en[1]  = 1'b0;
      `P3FS_FN_FOURTH: fn_val[1] = uart_transmit_i;
      default:         fn_val[1] = pin_data_ff[1];
    endcase
    case (fn_code[2])
      `P3FS_FN_SECOND: fn_val[2] = 1'b0;
      `P3FS_FN_THIRD: begin
        fn_val[2] = serial_clock_out_i;
        fn_en[2]  = serial_clock_oe_i;
      end
      `P3FS_FN_FOURTH: fn_val[2] = function_timer_out_ch4_i;
      default:         fn_val[2] = pin_data_ff[2];
    endcase
    case (fn_code[3])
      `P3FS_FN_SECOND: fn_val[3] = buzzer_output_i;
      `P3FS_FN_THIRD:  fn_val[3] = 1'b0;
      `P3FS_FN_FOURTH: fn_val[3] = function_timer_out_ch5_i;
      default:         fn_val[3] = pin_data_ff[3];
    endcase
    case (fn_code[4])
      `P3FS_FN_SECOND: fn_val[4] = ~i2c1_sda_low_i;
      `P3FS_FN_THIRD:  fn_val[4] = fifo_serial_data_out_i;
      `P3FS_FN_FOURTH: fn_en[4]  = 1'b0;
      default:         fn_val[4] = pin_data_ff[4];
    endcase
    case (fn_code[5])
      `P3FS_FN_SECOND: fn_val[5] = ~i2c1_scl_low_i;
      `P3FS_FN_THIRD:  fn_en[5]  = 1'b0;
      `P3FS_FN_FOURTH: fn_val[5] = fifo_uart_transmit_i;
      default:         fn_val[5] = pin_data_ff[5];
    endcase
    case (fn_code[6])
      `P3FS_FN_SECOND: fn_val[6] = 1'b0;
      `P3FS_FN_THIRD: begin
        fn_val[6] = fifo_serial_clock_out_i;
        fn_en[6]  = fifo_serial_clock_oe_i;
      end
      `P3FS_FN_FOURTH: fn_val[6] = function_timer_out_ch6_i;
      default:         fn_val[6] = pin_data_ff[6];
    endcase
    case (fn_code[7])
      `P3FS_FN_SECOND: fn_val[7] = 1'b0;
      `P3FS_FN_THIRD: begin
        fn_val[7] = fifo_serial_chip_select_out_i;
        fn_en[7]  = fifo_serial_chip_select_oe_i;
      end
      `P3FS_FN_FOURTH: fn_val[7] = function_timer_out_ch7_i;
      default:         fn_val[7] = pin_data_ff[7];
    endcase
  end

  // Drive stage: direction then drive type, per pin
  // Pulls only in input direction, so a pin never pulls while driving
  always @* begin
    nxt_pin_out   = 8'h00;
    nxt_pin_oe    = 8'h00;
    nxt_pull_up   = 8'h00;
    nxt_pull_down = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (pin_direction_ff[i] == `P3FS_DIR_OUT) begin
        case (drv_code[i])
          `P3FS_DRV_POD: begin
            nxt_pin_out[i] = 1'b1;
            nxt_pin_oe[i]  = fn_en[i] & fn_val[i];
          end
          `P3FS_DRV_NOD: begin
            nxt_pin_out[i] = 1'b0;
            nxt_pin_oe[i]  = fn_en[i] & ~fn_val[i];
          end
          `P3FS_DRV_CMOS: begin
            nxt_pin_out[i] = fn_val[i];
            nxt_pin_oe[i]  = fn_en[i];
          end
          default: begin
            nxt_pin_out[i] = 1'b0;
            nxt_pin_oe[i]  = 1'b0;
          end
        endcase
      end else begin
        nxt_pull_down[i] = (drv_code[i] == `P3FS_DRV_POD);
        nxt_pull_up[i]   = (drv_code[i] == `P3FS_DRV_NOD);
      end
    end
  end

  // Pin controls leave flip-flops so pads see no decode glitches
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_out_ff   <= 8'h00;
      pin_oe_ff    <= 8'h00;
      pull_up_ff   <= 8'h00;
      pull_down_ff <= 8'h00;
    end else begin
      pin_out_ff   <= nxt_pin_out;
      pin_oe_ff    <= nxt_pin_oe;
      pull_up_ff   <= nxt_pull_up;
      pull_down_ff <= nxt_pull_down;
    end
  end

  assign pin_out_o   = pin_out_ff;
  assign pin_oe_o    = pin_oe_ff;
  assign pull_up_o   = pull_up_ff;
  assign pull_down_o = pull_down_ff;

  // Unselected peripheral inputs idle high, the serial bus rest level
  // A deselected function sees no edges from its pin
  assign i2c0_sda_in_o = (fn_code[0] == `P3FS_FN_SECOND) ?
                         pin_level_ff[0] : `P3FS_IDLE_LEVEL;
  assign uart_receive_o = (fn_code[0] == `P3FS_FN_FOURTH) ?
                          pin_level_ff[0] : `P3FS_IDLE_LEVEL;
  assign i2c0_scl_in_o = (fn_code[1] == `P3FS_FN_SECOND) ?
                         pin_level_ff[1] : `P3FS_IDLE_LEVEL;
  assign serial_data_in_o = (fn_code[1] == `P3FS_FN_THIRD) ?
                            pin_level_ff[1] : `P3FS_IDLE_LEVEL;
  assign serial_clock_in_o = (fn_code[2] == `P3FS_FN_THIRD) ?
                             pin_level_ff[2] : `P3FS_IDLE_LEVEL;
  assign i2c1_sda_in_o = (fn_code[4] == `P3FS_FN_SECOND) ?
                         pin_level_ff[4] : `P3FS_IDLE_LEVEL;
  assign fifo_uart_receive_o = (fn_code[4] == `P3FS_FN_FOURTH) ?
                               pin_level_ff[4] : `P3FS_IDLE_LEVEL;
  assign i2c1_scl_in_o = (fn_code[5] == `P3FS_FN_SECOND) ?
                         pin_level_ff[5] : `P3FS_IDLE_LEVEL;
  assign fifo_serial_data_in_o = (fn_code[5] == `P3FS_FN_THIRD) ?
                                 pin_level_ff[5] : `P3FS_IDLE_LEVEL;
  assign fifo_serial_clock_in_o = (fn_code[6] == `P3FS_FN_THIRD) ?
                                  pin_level_ff[6] : `P3FS_IDLE_LEVEL;
  assign fifo_serial_chip_select_in_o = (fn_code[7] == `P3FS_FN_THIRD) ?
                                        pin_level_ff[7] : `P3FS_IDLE_LEVEL;

  // Interrupt sense only in I/O function with input direction
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_irq
      assign external_irq_in_o[g] = (fn_code[g] == `P3FS_FN_IO) &
                                    (pin_direction_ff[g] == `P3FS_DIR_IN) &
                                    pin_level_ff[g];
    end
  endgenerate

endmodule
`default_nettype wire

// ---- p3fs_regs.vh ----
// Register map, field codes and reset values of the port function select block
`ifndef P3FS_REGS_VH
`define P3FS_REGS_VH

`define P3FS_ADDR_W         16
`define P3FS_OFS_DATA       16'hF220
`define P3FS_OFS_DIR        16'hF224
`define P3FS_OFS_CTRL       16'hF228
`define P3FS_OFS_MODE       16'hF22C

`define P3FS_RST_DATA       8'h00
`define P3FS_RST_DIR        8'h00
`define P3FS_RST_CTRL       16'h0000
`define P3FS_RST_MODE       16'h0000

`define P3FS_HI_BYTE_LSB    8
`define P3FS_DIR_OUT        1'b0
`define P3FS_DIR_IN         1'b1

`define P3FS_FN_IO          2'h0
`define P3FS_FN_SECOND      2'h1
`define P3FS_FN_THIRD       2'h2
`define P3FS_FN_FOURTH      2'h3

`define P3FS_DRV_HIZ        2'h0
`define P3FS_DRV_POD        2'h1
`define P3FS_DRV_NOD        2'h2
`define P3FS_DRV_CMOS       2'h3

`define P3FS_IDLE_LEVEL     1'b1

`endif

// ---- p3fs_port_chk.sv ----
// Port-level assertions for the port function select block
`timescale 1ns/1ps
`default_nettype none
`include "p3fs_regs.vh"
module p3fs_port_chk (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [15:0] paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  pin_in_i,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  pull_up_o,
  input wire logic [7:0]  pull_down_o,
  input wire logic        i2c0_sda_in_o,
  input wire logic        uart_receive_o,
  input wire logic [7:0]  external_irq_in_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  property p_ready; psel_i |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("pready low in transfer");
  property p_err_map;
    psel_i && penable_i |-> pslverr_o == !(paddr_i inside
      {`P3FS_OFS_DATA, `P3FS_OFS_DIR, `P3FS_OFS_CTRL, `P3FS_OFS_MODE});
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  // Two edges: no write can have reached the pins yet
  property p_reset_hiz;
    $fell(reset_i) |-> (pin_oe_o == 8'h00 && (pull_up_o | pull_down_o) == 8'h00) [*2];
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");
  property p_pull_excl; (pull_up_o & pull_down_o) == 8'h00; endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_pull_in; ((pull_up_o | pull_down_o) & pin_oe_o) == 8'h00; endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull while driving");
  property p_irq_level; (external_irq_in_o & ~$past(pin_in_i)) == 8'h00; endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq input not pin level");
  property p_irq_excl; external_irq_in_o[0] |-> i2c0_sda_in_o && uart_receive_o; endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("irq and function both on");
  property p_pin0_in; !(i2c0_sda_in_o && uart_receive_o) |-> !$past(pin_in_i[0]); endproperty
  a_pin0_in: assert property (p_pin0_in) else $error("pin0 function input wrong");
endmodule
bind p3fs_port p3fs_port_chk u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_in_i(pin_in_i),
  .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
  .i2c0_sda_in_o(i2c0_sda_in_o), .uart_receive_o(uart_receive_o),
  .external_irq_in_o(external_irq_in_o)
);
`default_nettype wire

// ---- p3fs_pins.sv ----
// Far-side pad model: resolves each pin from design drive, external drivers and pulls
`timescale 1ns/1ps
`default_nettype none
module p3fs_pins (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] pin_out_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pull_up_i,
  input  wire logic [7:0] pull_down_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pin_o
);
  logic [7:0] float_ff = 8'h00;
  // Undriven pads wander so nothing can lean on a stale level
  always @(posedge ref_clk_i) float_ff <= ~float_ff;
  always_comb
    for (int i = 0; i < 8; i++)
      pin_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                 pull_up_i[i] ? 1'b1 : pull_down_i[i] ? 1'b0 : float_ff[i];
endmodule
`default_nettype wire

// ---- port3_io_function_select_tb.sv ----
// Self-checking bench for the port function select block
`timescale 1ns/1ps
`default_nettype none
`include "p3fs_regs.vh"
module port3_io_function_select_tb;
  logic        ref_clk_i;
  logic        reset_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [18:0] periph;
  logic [7:0]  ext_val;
  logic [7:0]  ext_en;
  wire  [31:0] prdata;
  wire         pslverr;
  wire         pready;
  wire  [7:0]  pin_lvl, pin_out, pin_oe, pull_up, pull_down, irq;
  wire  [10:0] fin;
  int          err_total;
  int          cmp_count;
  p3fs_port dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .pin_in_i(pin_lvl),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pull_up_o(pull_up), .pull_down_o(pull_down),
    .i2c0_sda_low_i(periph[0]), .i2c0_scl_low_i(periph[1]), .i2c1_sda_low_i(periph[2]),
    .i2c1_scl_low_i(periph[3]), .serial_data_out_i(periph[4]),
    .serial_clock_out_i(periph[5]), .serial_clock_oe_i(periph[6]),
    .uart_transmit_i(periph[7]), .buzzer_output_i(periph[8]),
    .function_timer_out_ch4_i(periph[9]), .function_timer_out_ch5_i(periph[10]),
    .function_timer_out_ch6_i(periph[11]), .function_timer_out_ch7_i(periph[12]),
    .fifo_serial_data_out_i(periph[13]), .fifo_serial_clock_out_i(periph[14]),
    .fifo_serial_clock_oe_i(periph[15]), .fifo_serial_chip_select_out_i(periph[16]),
    .fifo_serial_chip_select_oe_i(periph[17]), .fifo_uart_transmit_i(periph[18]),
    .i2c0_sda_in_o(fin[0]), .i2c0_scl_in_o(fin[1]), .i2c1_sda_in_o(fin[2]),
    .i2c1_scl_in_o(fin[3]), .serial_data_in_o(fin[4]), .serial_clock_in_o(fin[5]),
    .uart_receive_o(fin[6]), .fifo_serial_data_in_o(fin[7]),
    .fifo_serial_clock_in_o(fin[8]), .fifo_serial_chip_select_in_o(fin[9]),
    .fifo_uart_receive_o(fin[10]), .external_irq_in_o(irq)
  );
  p3fs_pins u_pins (
    .ref_clk_i(ref_clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pull_up_i(pull_up),
    .pull_down_i(pull_down), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_lvl)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic final_report;
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge ref_clk_i);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, s};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave's answer
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    logic [31:0] q;
    apb(1'b1, a, {16'h0000, d}, s, q);
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, 4'h0, q);
    chk(what, e, q);
  endtask
  // Pin edge, then input sampling edge, then one spare edge
  task automatic settle;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic t_reset;
    chk("pin_oe", 8'h00, pin_oe);
    chk("fn_inputs", 11'h7FF, fin);
    rd_chk("mode", `P3FS_OFS_MODE, 32'h0000_0000);
    rd_chk("dir", `P3FS_OFS_DIR, 32'h0000_0000);
    rd_chk("ctrl", `P3FS_OFS_CTRL, 32'h0000_0000);
    rd_chk("unmapped", 16'hF230, 32'h0000_0000);
  endtask
  task automatic t_mode_bytes;
    wr(`P3FS_OFS_MODE, 16'h00A5, 4'h1);
    wr(`P3FS_OFS_MODE, 16'h3C00, 4'h2);
    rd_chk("mode_word", `P3FS_OFS_MODE, 32'h0000_3CA5);
    wr(`P3FS_OFS_MODE, 16'hFF5A, 4'h1);
    rd_chk("mode_low", `P3FS_OFS_MODE, 32'h0000_3C5A);
    wr(`P3FS_OFS_MODE, 16'h0000);
  endtask
  task automatic t_out_drive;
    wr(`P3FS_OFS_DATA, 16'h005A);
    for (int c = 0; c < 4; c++) begin
      wr(`P3FS_OFS_CTRL, {{8{c[1]}}, {8{c[0]}}});
      settle();
      chk("oe", c == 0 ? 8'h00 : c == 1 ? 8'h5A : c == 2 ? 8'hA5 : 8'hFF, pin_oe);
      chk("drive", c[0] ? 8'h5A : 8'h00, pin_out & pin_oe);
      if (c == 0) chk("analog_hiz", 4'h0, pin_oe[7:4] | pull_up[7:4]);
      rd_chk("data_out", `P3FS_OFS_DATA, 32'h0000_005A);
    end
  endtask
  task automatic t_in_mode;
    wr(`P3FS_OFS_DIR, 16'h00FF);
    for (int c = 0; c < 4; c++) begin
      wr(`P3FS_OFS_CTRL, {{8{c[1]}}, {8{c[0]}}});
      settle();
      chk("pull_up", c == 2 ? 8'hFF : 8'h00, pull_up);
      chk("pull_down", c == 1 ? 8'hFF : 8'h00, pull_down);
      chk("in_oe", 8'h00, pin_oe);
    end
    @(posedge ref_clk_i);
    ext_val <= 8'hA6;
    ext_en <= 8'hFF;
    wr(`P3FS_OFS_DIR, 16'h000F);
    settle();
    chk("mixed_oe", 8'hF0, pin_oe);
    chk("irq", 8'h06, irq);
    rd_chk("data_in", `P3FS_OFS_DATA, 32'h0000_0056);
  endtask
  task automatic t_prohibited;
    wr(`P3FS_OFS_DIR, 16'h0000);
    wr(`P3FS_OFS_DATA, 16'h00FF);
    wr(`P3FS_OFS_MODE, 16'h0080);
    for (int c = 0; c < 4; c++) begin
      wr(`P3FS_OFS_CTRL, {{8{c[1]}}, {8{c[0]}}});
      settle();
      chk("prohib_oe", c[1], pin_oe[7]);
      chk("prohib_low", 1'b0, pin_out[7] & pin_oe[7]);
    end
  endtask
  // Source index, inverted-source flag, input-only flag, function input index
  function automatic logic [10:0] fm(input logic [4:0] k);
    case (k)
      5'h01: fm = {5'h00, 2'h2, 4'h0};
      5'h02: fm = {5'h04, 2'h0, 4'hF};
      5'h03: fm = {5'h1F, 2'h1, 4'h6};
      5'h05: fm = {5'h01, 2'h2, 4'h1};
      5'h06: fm = {5'h1F, 2'h1, 4'h4};
      5'h07: fm = {5'h07, 2'h0, 4'hF};
      5'h0A: fm = {5'h05, 2'h0, 4'h5};
      5'h0B: fm = {5'h09, 2'h0, 4'hF};
      5'h0D: fm = {5'h08, 2'h0, 4'hF};
      5'h0F: fm = {5'h0A, 2'h0, 4'hF};
      5'h11: fm = {5'h02, 2'h2, 4'h2};
      5'h12: fm = {5'h0D, 2'h0, 4'hF};
      5'h13: fm = {5'h1F, 2'h1, 4'hA};
      5'h15: fm = {5'h03, 2'h2, 4'h3};
      5'h16: fm = {5'h1F, 2'h1, 4'h7};
      5'h17: fm = {5'h12, 2'h0, 4'hF};
      5'h1A: fm = {5'h0E, 2'h0, 4'h8};
      5'h1B: fm = {5'h0B, 2'h0, 4'hF};
      5'h1E: fm = {5'h10, 2'h0, 4'h9};
      5'h1F: fm = {5'h0C, 2'h0, 4'hF};
      default: fm = {5'h1F, 2'h0, 4'hF};
    endcase
  endfunction
  task automatic t_routing;
    logic [10:0] m;
    logic [10:0] e;
    for (int p = 0; p < 8; p++)
      for (int c = 1; c < 4; c++) begin
        m = fm({p[2:0], c[1:0]});
        wr(`P3FS_OFS_MODE, (16'(c[1]) << (p + 8)) | (16'(c[0]) << p));
        for (int ph = 0; ph < 2; ph++) begin
          @(posedge ref_clk_i);
          periph <= 19'h28040 | (ph != 0 ? 19'h00000 : 19'h00001 << m[10:6]);
          settle();
          e = 11'h7FF;
          if (m[3:0] != 4'hF)
            e[m[3:0]] = pin_lvl[p];
          chk("fn_inputs", e, fin);
          if (m[4])
            chk("fn_oe", 1'b0, pin_oe[p]);
          else
            chk("fn_pin", {1'b1, m[10:6] != 5'h1F && m[5] == ph[0]}, {pin_oe[p], pin_out[p]});
        end
      end
  endtask
  // Clock and chip-select functions follow their own enables
  task automatic t_oe_release;
    wr(`P3FS_OFS_MODE, 16'hC400);
    @(posedge ref_clk_i);
    periph <= 19'h00000;
    settle();
    chk("fn_oe_off", 6'h05, {pin_oe[7:6], pin_oe[2], fin[9], fin[8], fin[5]});
    @(posedge ref_clk_i);
    periph <= 19'h3C060;
    settle();
    chk("fn_oe_on", 6'h3F, {pin_oe[7:6], pin_oe[2], pin_out[7:6], pin_out[2]});
    chk("fn_in_on", 3'h7, {fin[9], fin[8], fin[5]});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    reset_i = 1'b1;
    periph = 19'h28040;
    ext_val = 8'h00;
    ext_en = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_mode_bytes();
    t_out_drive();
    t_in_mode();
    t_prohibited();
    t_routing();
    t_oe_release();
    final_report();
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
